// ==== pkg/xcr_regs.svh ====
/*
  Register offsets, field positions and reset values of the control register bank.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef XCR_REGS_SVH
`define XCR_REGS_SVH

// ----------------------------------------------------------------
// Byte offsets on the APB
// ----------------------------------------------------------------
`define XCR_SYSCTL_OFF 12'h000
`define XCR_RSVD_OFF 12'h004
`define XCR_FAULT_OFF 12'h008
`define XCR_PDBASE_OFF 12'h00c
`define XCR_FEAT_OFF 12'h010
`define XCR_EVT_OFF 12'h014

// ----------------------------------------------------------------
// System control fields
// ----------------------------------------------------------------
`define XCR_PE 0
`define XCR_MP 1
`define XCR_EM 2
`define XCR_TS 3
`define XCR_FIXED1 4
`define XCR_NE 5
`define XCR_WP 16
`define XCR_AM 18
`define XCR_NW 29
`define XCR_CD 30
`define XCR_PG 31
// Writable bits of system control; reserved bits keep their value
`define XCR_SYSCTL_WMASK 32'he005002f
`define XCR_SYSCTL_RESET 32'h00000010

// ----------------------------------------------------------------
// Page directory base fields
// ----------------------------------------------------------------
`define XCR_PWT 3
`define XCR_PCD 4
`define XCR_PDBASE_WMASK 32'hfffff018
`define XCR_PDBASE_RESET 32'h00000000
`define XCR_PDIR_LO 12

// ----------------------------------------------------------------
// Feature control fields
// ----------------------------------------------------------------
`define XCR_TSD 2
`define XCR_DE 3
`define XCR_PGE 7
`define XCR_PCE 8
`define XCR_FEAT_WMASK 32'h0000018c
`define XCR_FEAT_RESET 32'h00000000

// Debug breakpoint type codes
`define XCR_BP_EXEC 2'h0
`define XCR_BP_WRITE 2'h1
`define XCR_BP_IO 2'h2
`define XCR_BP_RW 2'h3

// Floating point fault vector
`define XCR_DNA_VECTOR 8'h07
`define XCR_FPU_INT_VECTOR 8'h10

`endif

// ==== pkg/xcr_pkg.sv ====
/*
  Types shared by the control register bank.
  Assumes the core supplies events synchronous to the one clock.
*/
`include "xcr_regs.svh"

package xcr_pkg;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } xcr_apb_req_t;

  // Core event inputs
  typedef struct packed {
    logic pageFault;
    logic [31:0] faultLinearAddress;
    logic taskSwitch;
  } xcr_core_evt_t;

  // Whole state of the bank
  typedef struct packed {
    logic [31:0] sysCtl;
    logic [31:0] faultAddr;
    logic [31:0] pdBase;
    logic [31:0] featCtl;
    logic [31:0] prdata;
    logic tlbFlushAll;
    logic tlbFlushNonGlobal;
  } xcr_state_t;

  // Breakpoint kind decoded from a debug type field
  typedef enum logic [2:0] {
    BP_EXECUTE,
    BP_DATA_WRITE,
    BP_IO_ACCESS,
    BP_DATA_RW,
    BP_INVALID
  } xcr_bp_kind_t;

endpackage : xcr_pkg

// ==== rtl/xcr_control_bank.sv ====
/*
  Control register bank of an x86 core: system control, fault address,
  page directory base, a reserved register and feature control, on APB.
  Assumes core events and decode requests are synchronous to clk.
*/
// What this block does
// RULE1 - Page fault with paging loads fault address
// RULE2 - Later fault overwrites earlier fault address
// RULE3 - Directory base bits 31..12, low zero
// RULE4 - Unpaged cycles drive cache-disable pin
// RULE5 - Unpaged cycles drive write-through pin
// RULE6 - Reserved register reads zero always
// RULE7 - Timestamp read privileged when bit set
// RULE8 - Debug extensions enable I/O breakpoint decode
// RULE9 - Global entries survive flushes when enabled
// RULE10 - Perf counter read allowed anywhere if set
// RULE11 - Paging needs paging bit and protection
// RULE12 - Software branches after changing paging bit
// RULE13 - Cache fill disable stops line fills
// RULE14 - Write-through select issues every write
// RULE15 - Alignment faults only when mask set
// RULE16 - Write protect faults supervisor writes
// RULE17 - Float fault vector select picks reporting
// RULE18 - Task switch sets flag; float faults
// RULE19 - Trap-all faults every float instruction
// RULE20 - Monitor with flag faults WAIT only
// RULE21 - Protection bit selects protected/real mode
// RULE22 - Software keeps reserved control bits
// RULE23 - Joint decode of float fault bits
// RULE24 - Reserved writes ignored, reserved bits kept
`include "xcr_regs.svh"
module xcr_control_bank
  import xcr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire xcr_apb_req_t apbReq,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Core events
  input wire xcr_core_evt_t coreEvt,
  // Bus cycle attributes
  input wire logic cycleTranslated,
  input wire logic pageCacheDisableIn,
  input wire logic pageWriteThroughIn,
  output logic cacheDisablePin,
  output logic writeThroughPin,
  // Instruction permission decode
  input wire logic [1:0] currentPrivilegeLevel,
  input wire logic isFloatInstr,
  input wire logic isWaitInstr,
  input wire logic [1:0] bpTypeField,
  input wire logic writeToReadOnly,
  input wire logic misaligned,
  input wire logic alignmentCheckFlag,
  output logic deviceNotAvailableFault,
  output logic [7:0] fpuFaultVector,
  output logic timestampReadAllowed,
  output logic perfCounterReadAllowed,
  output xcr_bp_kind_t bpKind,
  output logic writeProtectFault,
  output logic alignmentFault,
  // Mode and cache controls
  output logic pagingEnabled,
  output logic protectedMode,
  output logic cacheFillDisable,
  output logic writeThroughSelect,
  output logic [31:0] pageDirectoryAddr,
  output logic tlbFlushAll,
  output logic tlbFlushNonGlobal
);

  xcr_state_t s_q;
  xcr_state_t s_d;

  logic wrEn;
  logic rdEn;
  logic addrOk;
  logic [31:0] rdVal;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign rdEn = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;

  always_comb
  begin
    addrOk = 1'b1;
    rdVal = 32'h00000000;
    case (apbReq.paddr)
      `XCR_SYSCTL_OFF: rdVal = s_q.sysCtl;
      `XCR_RSVD_OFF: rdVal = 32'h00000000; // see RULE6
      `XCR_FAULT_OFF: rdVal = s_q.faultAddr;
      `XCR_PDBASE_OFF: rdVal = s_q.pdBase;
      `XCR_FEAT_OFF: rdVal = s_q.featCtl;
      `XCR_EVT_OFF: rdVal = {30'h00000000, s_q.tlbFlushNonGlobal, s_q.tlbFlushAll};
      default: addrOk = 1'b0;
    endcase
  end

  // Unmapped addresses answer with an error in the access phase
  assign pslverr = apbReq.psel & apbReq.penable & ~addrOk;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.tlbFlushAll = 1'b0;
    s_d.tlbFlushNonGlobal = 1'b0;
    // Read data captured in setup so it is a flop during access
    if (rdEn)
    begin
      s_d.prdata = rdVal;
    end
    if (wrEn)
    begin
      case (apbReq.paddr)
        `XCR_SYSCTL_OFF:
        begin
          // Reserved bits keep their value; the fixed-one bit stays one
          s_d.sysCtl = (s_q.sysCtl & ~`XCR_SYSCTL_WMASK) | (apbReq.pwdata & `XCR_SYSCTL_WMASK); // see RULE24
        end
        `XCR_FAULT_OFF: s_d.faultAddr = apbReq.pwdata;
        `XCR_PDBASE_OFF:
        begin
          s_d.pdBase = (s_q.pdBase & ~`XCR_PDBASE_WMASK) | (apbReq.pwdata & `XCR_PDBASE_WMASK); // see RULE24
          // A new directory base flushes the TLB, sparing global entries when enabled
          if (s_q.featCtl[`XCR_PGE])
          begin
            s_d.tlbFlushNonGlobal = 1'b1; // see RULE9
          end
          else
          begin
            s_d.tlbFlushAll = 1'b1;
          end
        end
        `XCR_FEAT_OFF:
        begin
          s_d.featCtl = (s_q.featCtl & ~`XCR_FEAT_WMASK) | (apbReq.pwdata & `XCR_FEAT_WMASK); // see RULE24
        end
        default:
        begin
          // Reserved register and unmapped writes are dropped
          s_d.sysCtl = s_d.sysCtl; // see RULE24
        end
      endcase
    end
    // Hardware events win over a software write in the same cycle
    if (coreEvt.taskSwitch)
    begin
      s_d.sysCtl[`XCR_TS] = 1'b1; // see RULE18
      if (s_q.featCtl[`XCR_PGE])
      begin
        s_d.tlbFlushNonGlobal = 1'b1; // see RULE9
        s_d.tlbFlushAll = 1'b0;
      end
      else
      begin
        s_d.tlbFlushAll = 1'b1;
      end
    end
    if (coreEvt.pageFault && pagingEnabled)
    begin
      // Latest fault always overwrites, so a nested fault leaves its own address
      s_d.faultAddr = coreEvt.faultLinearAddress; // see RULE1 see RULE2
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q.sysCtl <= `XCR_SYSCTL_RESET;
      s_q.faultAddr <= 32'h00000000;
      s_q.pdBase <= `XCR_PDBASE_RESET;
      s_q.featCtl <= `XCR_FEAT_RESET;
      s_q.prdata <= 32'h00000000;
      s_q.tlbFlushAll <= 1'b0;
      s_q.tlbFlushNonGlobal <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign tlbFlushAll = s_q.tlbFlushAll;
  assign tlbFlushNonGlobal = s_q.tlbFlushNonGlobal;

  // ----------------------------------------------------------------
  // Mode and cache controls
  // ----------------------------------------------------------------
  // Software must branch after toggling paging; no pipeline interlock here
  assign protectedMode = s_q.sysCtl[`XCR_PE]; // see RULE21
  assign pagingEnabled = s_q.sysCtl[`XCR_PG] & s_q.sysCtl[`XCR_PE]; // see RULE11 see RULE12
  assign cacheFillDisable = s_q.sysCtl[`XCR_CD]; // see RULE13
  assign writeThroughSelect = s_q.sysCtl[`XCR_NW]; // see RULE14
  assign pageDirectoryAddr = {s_q.pdBase[31:`XCR_PDIR_LO], 12'h000}; // see RULE3

  // Untranslated cycles take the register bits, translated ones the page entry only while paging is enabled
  assign cacheDisablePin = (cycleTranslated && pagingEnabled) ? pageCacheDisableIn :
                           s_q.pdBase[`XCR_PCD]; // see RULE4
  assign writeThroughPin = (cycleTranslated && pagingEnabled) ? pageWriteThroughIn :
                           s_q.pdBase[`XCR_PWT]; // see RULE5

  // ----------------------------------------------------------------
  // Permission and fault decode
  // ----------------------------------------------------------------
  logic tsBit;
  logic emBit;
  logic mpBit;
  assign tsBit = s_q.sysCtl[`XCR_TS];
  assign emBit = s_q.sysCtl[`XCR_EM];
  assign mpBit = s_q.sysCtl[`XCR_MP];

  always_comb
  begin
    deviceNotAvailableFault = 1'b0;
    if (isWaitInstr)
    begin
      deviceNotAvailableFault = tsBit & mpBit; // see RULE20 see RULE23
    end
    else if (isFloatInstr)
    begin
      deviceNotAvailableFault = emBit | tsBit; // see RULE18 see RULE19 see RULE23
    end
  end

  // Vector 7 on device not available; else for a float exception 16 internally, else external line
  assign fpuFaultVector = deviceNotAvailableFault ? `XCR_DNA_VECTOR :
                          (s_q.sysCtl[`XCR_NE] ? `XCR_FPU_INT_VECTOR : 8'h00); // see RULE17

  assign timestampReadAllowed = ~s_q.featCtl[`XCR_TSD] | (currentPrivilegeLevel == 2'h0); // see RULE7
  assign perfCounterReadAllowed = s_q.featCtl[`XCR_PCE] | (currentPrivilegeLevel == 2'h0); // see RULE10

  always_comb
  begin
    bpKind = BP_INVALID;
    case (bpTypeField)
      `XCR_BP_EXEC: bpKind = BP_EXECUTE;
      `XCR_BP_WRITE: bpKind = BP_DATA_WRITE;
      `XCR_BP_IO: bpKind = s_q.featCtl[`XCR_DE] ? BP_IO_ACCESS : BP_INVALID; // see RULE8
      `XCR_BP_RW: bpKind = BP_DATA_RW;
      default: bpKind = BP_INVALID;
    endcase
  end

  // Level 3 always faults; supervisor levels only with write protect
  assign writeProtectFault = writeToReadOnly &
                             ((currentPrivilegeLevel == 2'h3) | s_q.sysCtl[`XCR_WP]); // see RULE16
  assign alignmentFault = misaligned & alignmentCheckFlag & s_q.sysCtl[`XCR_AM]; // see RULE15

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence faultSeen;
    coreEvt.pageFault && pagingEnabled;
  endsequence

  a_fault_addr_load: assert property (@(posedge clk) disable iff (!rstn)
    faultSeen |=> (s_q.faultAddr == $past(coreEvt.faultLinearAddress))) // see RULE1
    else $error("fault address not loaded");

  a_second_fault: assert property (@(posedge clk) disable iff (!rstn)
    faultSeen ##1 faultSeen |=> (s_q.faultAddr == $past(coreEvt.faultLinearAddress))) // see RULE2
    else $error("second fault address lost");

  a_pdir_align: assert property (@(posedge clk) disable iff (!rstn)
    pageDirectoryAddr == {s_q.pdBase[31:12], 12'h000}) // see RULE3
    else $error("directory address misaligned");

  a_pcd_pin: assert property (@(posedge clk) disable iff (!rstn)
    (!cycleTranslated || !pagingEnabled) |-> (cacheDisablePin == s_q.pdBase[4])) // see RULE4
    else $error("cache disable pin wrong");

  a_pwt_pin: assert property (@(posedge clk) disable iff (!rstn)
    (!cycleTranslated || !pagingEnabled) |-> (writeThroughPin == s_q.pdBase[3])) // see RULE5
    else $error("write through pin wrong");

  a_rsvd_read: assert property (@(posedge clk) disable iff (!rstn)
    (rdEn && apbReq.paddr == `XCR_RSVD_OFF) |=> (prdata == 32'h00000000)) // see RULE6
    else $error("reserved register not zero");

  a_tsc_priv: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.featCtl[2] && currentPrivilegeLevel != 2'h0) |-> !timestampReadAllowed) // see RULE7
    else $error("timestamp read allowed");

  a_io_bp: assert property (@(posedge clk) disable iff (!rstn)
    (bpTypeField == 2'h2) |-> ((bpKind == BP_IO_ACCESS) == s_q.featCtl[3])) // see RULE8
    else $error("io breakpoint decode wrong");

  a_global_keep: assert property (@(posedge clk) disable iff (!rstn)
    (coreEvt.taskSwitch && s_q.featCtl[7]) |=> (tlbFlushNonGlobal && !tlbFlushAll)) // see RULE9
    else $error("global entries flushed");

  a_pmc_priv: assert property (@(posedge clk) disable iff (!rstn)
    (!s_q.featCtl[8] && currentPrivilegeLevel != 2'h0) |-> !perfCounterReadAllowed) // see RULE10
    else $error("perf counter read allowed");

  a_paging_pe: assert property (@(posedge clk) disable iff (!rstn)
    pagingEnabled |-> (s_q.sysCtl[31] && s_q.sysCtl[0])) // see RULE11
    else $error("paging without protection");

  a_ts_set: assert property (@(posedge clk) disable iff (!rstn)
    coreEvt.taskSwitch |=> s_q.sysCtl[3]) // see RULE18
    else $error("task switched not set");

  a_wait_fault: assert property (@(posedge clk) disable iff (!rstn)
    isWaitInstr |-> (deviceNotAvailableFault == (tsBit && mpBit))) // see RULE20
    else $error("wait fault decode wrong");

  a_float_fault: assert property (@(posedge clk) disable iff (!rstn)
    (isFloatInstr && !isWaitInstr) |-> (deviceNotAvailableFault == (emBit || tsBit))) // see RULE23
    else $error("float fault decode wrong");

  a_align_mask: assert property (@(posedge clk) disable iff (!rstn)
    !s_q.sysCtl[18] |-> !alignmentFault) // see RULE15
    else $error("alignment fault while masked");

  a_rsvd_keep: assert property (@(posedge clk) disable iff (!rstn)
    wrEn |=> ((s_q.sysCtl & ~`XCR_SYSCTL_WMASK) == $past(s_q.sysCtl & ~`XCR_SYSCTL_WMASK))) // see RULE24
    else $error("reserved bits changed");

  a_cd_write: assert property (@(posedge clk) disable iff (!rstn) // see RULE13
    (wrEn && apbReq.paddr == `XCR_SYSCTL_OFF) |=> (cacheFillDisable == $past(apbReq.pwdata[30])))
    else $error("cache fill disable not written");

  a_nw_write: assert property (@(posedge clk) disable iff (!rstn) // see RULE14
    (wrEn && apbReq.paddr == `XCR_SYSCTL_OFF) |=> (writeThroughSelect == $past(apbReq.pwdata[29])))
    else $error("write through select not written");

  a_pe_write: assert property (@(posedge clk) disable iff (!rstn) // see RULE21
    (wrEn && apbReq.paddr == `XCR_SYSCTL_OFF) |=> (protectedMode == $past(apbReq.pwdata[0])))
    else $error("protection bit not written");

  a_wp_super: assert property (@(posedge clk) disable iff (!rstn) // see RULE16
    (writeToReadOnly && currentPrivilegeLevel != 2'h3) |-> (writeProtectFault == s_q.sysCtl[16]))
    else $error("supervisor write protect wrong");

  a_ne_vector: assert property (@(posedge clk) disable iff (!rstn) // see RULE17
    !deviceNotAvailableFault |-> (fpuFaultVector == (s_q.sysCtl[5] ? 8'h10 : 8'h00)))
    else $error("float fault vector wrong");

  a_em_all: assert property (@(posedge clk) disable iff (!rstn) // see RULE19
    (isFloatInstr && !isWaitInstr && emBit) |-> deviceNotAvailableFault)
    else $error("trap all did not fault");

  a_dna_vector: assert property (@(posedge clk) disable iff (!rstn) // see RULE19
    deviceNotAvailableFault |-> (fpuFaultVector == 8'h07))
    else $error("device not available vector wrong");

  a_pdir_flush: assert property (@(posedge clk) disable iff (!rstn) // see RULE9
    (wrEn && apbReq.paddr == `XCR_PDBASE_OFF && !s_q.featCtl[7]) |=> tlbFlushAll)
    else $error("directory write did not flush");

  a_pmc_open: assert property (@(posedge clk) disable iff (!rstn) // see RULE10
    s_q.featCtl[8] |-> perfCounterReadAllowed)
    else $error("perf counter read refused");

  a_tsc_open: assert property (@(posedge clk) disable iff (!rstn) // see RULE7
    !s_q.featCtl[2] |-> timestampReadAllowed)
    else $error("timestamp read refused");

endmodule : xcr_control_bank

// ==== test/xcr_control_bank_tb.sv ====
/*
  Self-checking bench for the control register bank: APB register traffic,
  core events and the decode outputs.
  Assumes the design answers APB with no wait states and one 200 MHz clock.
*/
`include "xcr_regs.svh"

module xcr_control_bank_tb;
  import xcr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rstn, pready, pslverr, er, seen;
  xcr_apb_req_t apbReq;
  logic [31:0] prdata, rd, pageDirectoryAddr;
  xcr_core_evt_t coreEvt;
  logic cycleTranslated, pageCacheDisableIn, pageWriteThroughIn, cacheDisablePin, writeThroughPin;
  logic [1:0] currentPrivilegeLevel, bpTypeField;
  logic isFloatInstr, isWaitInstr, writeToReadOnly, misaligned, alignmentCheckFlag;
  logic deviceNotAvailableFault, timestampReadAllowed, perfCounterReadAllowed;
  logic [7:0] fpuFaultVector;
  xcr_bp_kind_t bpKind;
  logic writeProtectFault, alignmentFault, pagingEnabled, protectedMode;
  logic cacheFillDisable, writeThroughSelect, tlbFlushAll, tlbFlushNonGlobal;
  int n_mismatch, tests_run, cyc;

  xcr_control_bank uut (.clk, .rstn, .apbReq, .pready, .pslverr, .prdata, .coreEvt, .cycleTranslated,
    .pageCacheDisableIn, .pageWriteThroughIn, .cacheDisablePin, .writeThroughPin, .currentPrivilegeLevel,
    .isFloatInstr, .isWaitInstr, .bpTypeField, .writeToReadOnly, .misaligned, .alignmentCheckFlag,
    .deviceNotAvailableFault, .fpuFaultVector, .timestampReadAllowed, .perfCounterReadAllowed, .bpKind,
    .writeProtectFault, .alignmentFault, .pagingEnabled, .protectedMode, .cacheFillDisable,
    .writeThroughSelect, .pageDirectoryAddr, .tlbFlushAll, .tlbFlushNonGlobal);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : xfer

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rdc

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdc(`XCR_SYSCTL_OFF, 32'h00000010, "sysctl reset");
    rdc(`XCR_RSVD_OFF, 32'h0, "rsvd reset");
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h1ffaffc0);
    rdc(`XCR_SYSCTL_OFF, 32'h00000010, "sysctl rsvd kept");
    xfer(1'b1, `XCR_PDBASE_OFF, 32'hffffffff);
    rdc(`XCR_PDBASE_OFF, 32'hfffff018, "pdbase mask");
    chk(pageDirectoryAddr, 32'hfffff000, "dir addr");
    xfer(1'b1, `XCR_FEAT_OFF, 32'hffffffff);
    rdc(`XCR_FEAT_OFF, 32'h0000018c, "feat mask");
    xfer(1'b1, `XCR_RSVD_OFF, 32'hffffffff);
    rdc(`XCR_RSVD_OFF, 32'h0, "rsvd write");
    xfer(1'b1, 12'h100, 32'h1);
    chk(32'(er), 32'h1, "unmapped err");
    xfer(1'b1, `XCR_FEAT_OFF, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_modes;
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h70050000);
    #1;
    chk({pagingEnabled, protectedMode, cacheFillDisable, writeThroughSelect}, 4'h3, "cd nw");
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h80000011);
    #1;
    chk({pagingEnabled, protectedMode}, 2'h3, "paging on");
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h80000010);
    #1;
    chk({pagingEnabled, protectedMode}, 2'h0, "paging needs pe");
    $display("test modes done");
  endtask : t_modes

  task automatic t_pins;
    xfer(1'b1, `XCR_PDBASE_OFF, 32'h00001010);
    cycleTranslated <= 1'b0;
    #1;
    chk({cacheDisablePin, writeThroughPin}, 2'h2, "pcd pin");
    xfer(1'b1, `XCR_PDBASE_OFF, 32'h00001008);
    #1;
    chk({cacheDisablePin, writeThroughPin}, 2'h1, "pwt pin");
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h80000011);
    {cycleTranslated, pageCacheDisableIn, pageWriteThroughIn} <= 3'h6;
    #1;
    chk({cacheDisablePin, writeThroughPin}, 2'h2, "paged pins");
    $display("test pins done");
  endtask : t_pins

  task automatic t_fault;
    @(posedge clk);
    coreEvt <= '{1'b1, 32'hdeadb004, 1'b0};
    @(posedge clk);
    coreEvt <= '{1'b1, 32'h12345678, 1'b0};
    @(posedge clk);
    coreEvt <= '{1'b1, 32'hfedcba98, 1'b0};
    @(posedge clk);
    coreEvt.pageFault <= 1'b0;
    rdc(`XCR_FAULT_OFF, 32'hfedcba98, "second fault");
    coreEvt <= '{1'b1, 32'h00abc123, 1'b0};
    @(posedge clk);
    coreEvt.pageFault <= 1'b0;
    rdc(`XCR_FAULT_OFF, 32'h00abc123, "fault addr");
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h80000010);
    coreEvt <= '{1'b1, 32'h5555aaaa, 1'b0};
    @(posedge clk);
    coreEvt.pageFault <= 1'b0;
    rdc(`XCR_FAULT_OFF, 32'h00abc123, "no paging no load");
    $display("test fault done");
  endtask : t_fault

  task automatic t_float;
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, `XCR_SYSCTL_OFF, 32'h10 | (32'(i[2]) << 2) | (32'(i[1]) << 3) | (32'(i[0]) << 1));
      {isWaitInstr, isFloatInstr} <= 2'h2;
      #1;
      chk(32'(deviceNotAvailableFault), 32'(i[1] & i[0]), "wait fault");
      @(posedge clk);
      {isWaitInstr, isFloatInstr} <= 2'h1;
      #1;
      chk(32'(deviceNotAvailableFault), 32'(i[2] | i[1]), "esc fault");
      chk(fpuFaultVector, (i[2] | i[1]) ? 8'h07 : 8'h00, "vector");
    end
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h00000030);
    #1;
    chk(fpuFaultVector, 8'h10, "ne vector");
    @(posedge clk);
    coreEvt <= '{1'b0, 32'h0, 1'b1};
    @(posedge clk);
    coreEvt.taskSwitch <= 1'b0;
    #1;
    chk(32'(deviceNotAvailableFault), 32'h1, "ts fault");
    chk(32'(tlbFlushAll), 32'h1, "full flush");
    rdc(`XCR_SYSCTL_OFF, 32'h00000038, "ts set");
    isFloatInstr <= 1'b0;
    $display("test float done");
  endtask : t_float

  task automatic t_feat;
    xfer(1'b1, `XCR_FEAT_OFF, 32'h0);
    {currentPrivilegeLevel, bpTypeField} <= 4'he;
    #1;
    chk({timestampReadAllowed, perfCounterReadAllowed}, 2'h2, "cpl3 off");
    chk(32'(bpKind), 32'(BP_INVALID), "io bp off");
    xfer(1'b1, `XCR_FEAT_OFF, 32'h0000010c);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      bpTypeField <= 2'(i);
      #1;
      chk(32'(bpKind), 32'(i), "bp kind");
    end
    chk({timestampReadAllowed, perfCounterReadAllowed}, 2'h1, "cpl3 on");
    @(posedge clk);
    currentPrivilegeLevel <= 2'h0;
    #1;
    chk({timestampReadAllowed, perfCounterReadAllowed}, 2'h3, "cpl0");
    xfer(1'b1, `XCR_FEAT_OFF, 32'h00000080);
    coreEvt <= '{1'b0, 32'h0, 1'b1};
    @(posedge clk);
    coreEvt.taskSwitch <= 1'b0;
    seen = 1'b0;
    repeat (3)
    begin
      @(negedge clk);
      seen = seen | tlbFlushNonGlobal;
      chk(32'(tlbFlushAll), 32'h0, "no full flush");
    end
    chk(32'(seen), 32'h1, "global kept");
    $display("test feat done");
  endtask : t_feat

  task automatic t_prot;
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h00000011);
    {writeToReadOnly, misaligned, alignmentCheckFlag, currentPrivilegeLevel} <= 5'h1c;
    #1;
    chk({writeProtectFault, alignmentFault}, 2'h0, "wp am clear");
    @(posedge clk);
    currentPrivilegeLevel <= 2'h3;
    #1;
    chk(32'(writeProtectFault), 32'h1, "user ro write");
    @(posedge clk);
    currentPrivilegeLevel <= 2'h0;
    xfer(1'b1, `XCR_SYSCTL_OFF, 32'h00050011);
    #1;
    chk({writeProtectFault, alignmentFault}, 2'h3, "wp am set");
    $display("test prot done");
  endtask : t_prot

  // ----------------------------------------------------------------
  // Clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial
  begin
    {rstn, cycleTranslated, pageCacheDisableIn, pageWriteThroughIn, isFloatInstr, isWaitInstr} = '0;
    {currentPrivilegeLevel, bpTypeField, writeToReadOnly, misaligned, alignmentCheckFlag} = '0;
    apbReq = '0;
    coreEvt = '0;
    {n_mismatch, tests_run, cyc} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_pins();
    t_fault();
    t_float();
    t_feat();
    t_prot();
    wrap_up();
  end
endmodule : xcr_control_bank_tb
